// >>> hw/brc_defines.vh
// Purpose: constants for the regulator control block
// Assumes: 250 MHz core clock
// Notes: offsets are byte register indices on the serial port
`ifndef BRC_DEFINES_VH
`define BRC_DEFINES_VH
`define BRC_OFS_SET_LOW 8'h00
`define BRC_OFS_SET_HIGH 8'h01
`define BRC_OFS_CONTROL 8'h02
`define BRC_OFS_IDENT1 8'h03
`define BRC_OFS_IDENT2 8'h04
`define BRC_OFS_REG_STATE 8'h05
`define BRC_RST_SET 8'hc8
`define BRC_RST_CONTROL 8'h82
`define BRC_IDENT1_VAL 8'h5a
`define BRC_IDENT2_VAL 8'ha5
`define BRC_STATE_OK 8'h81
`define BRC_STATE_OFF 8'h00
`define BRC_CTL_DISCH 7
`define BRC_CTL_RESET 2
`define BRC_SW_EN_BIT 7
`define BRC_ADDR_MAIN 7'h60
`define BRC_ADDR_ALT 7'h61
`define BRC_MCODE_TOP 5'h01
`define BRC_CLIM_COUNT 5'd16
`define BRC_HICCUP_US 1700
`define BRC_CLK_MHZ 250
`define BRC_HICCUP_CYC (`BRC_HICCUP_US * `BRC_CLK_MHZ)
`define BRC_SLEW_BASE_NS 98
`define BRC_SS_STEP_CYC 16'd256
`define BRC_OVP_FILT 4'd15
`define BRC_VBASE_UV 600000
`define BRC_VSTEP_NV 6250
`endif

// >>> hw/brc_i2c_slave.v
// Purpose: serial slave port with byte register access
// Assumes: bus lines already synchronised to clk_i
// Notes: sda_oe_n_o low means pulling the line low
`timescale 1ns/1ns
module brc_i2c_slave (
  input wire clk_i, // core clock
  input wire rst_i, // sync reset
  input wire ce_i, // clock enable
  input wire alt_addr_i, // alternate address option
  input wire scl_i, // synced clock line
  input wire sda_i, // synced data line
  output reg sda_oe_n_o, // data pull enable, active low
  output reg [7:0] addr_o, // register offset
  output reg [7:0] wdata_o, // write data
  output reg wr_o, // write strobe
  input wire [7:0] rdata_i, // read data for addr_o
  output reg hs_o // high speed mode
);
`include "brc_defines.vh"
  localparam ST_IDLE = 3'd0, ST_DEV = 3'd1, ST_OFS = 3'd2, ST_WR = 3'd3, ST_RD = 3'd4, ST_MCODE = 3'd5;
  reg scl_d_r, sda_d_r;
  reg [2:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg ack_r, rdack_r;
  wire scl_rise = scl_i & ~scl_d_r;
  wire scl_fall = ~scl_i & scl_d_r;
  wire start_c = scl_i & scl_d_r & sda_d_r & ~sda_i;
  wire stop_c = scl_i & scl_d_r & ~sda_d_r & sda_i;
  wire [7:0] sh_in = {sh_r[6:0], sda_i}; // msb first
  wire [6:0] my_addr = alt_addr_i ? `BRC_ADDR_ALT : `BRC_ADDR_MAIN;
  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      rdack_r <= 1'b0;
      sda_oe_n_o <= 1'b1;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
      wr_o <= 1'b0;
      hs_o <= 1'b0;
    end else if (ce_i) begin
      scl_d_r <= scl_i;
      sda_d_r <= sda_i;
      wr_o <= 1'b0;
      if (stop_c) begin
        st_r <= ST_IDLE;
        hs_o <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end else if (start_c) begin
        st_r <= ST_DEV; // repeated start keeps hs mode
        bit_r <= 4'h0;
        ack_r <= 1'b0;
        sda_oe_n_o <= 1'b1;
      end else if (scl_rise && st_r != ST_IDLE) begin
        if (ack_r) begin
          ack_r <= 1'b0;
          if (st_r == ST_RD && sda_i)
            st_r <= ST_IDLE; // master nack ends read
        end else begin
          sh_r <= sh_in;
          bit_r <= bit_r + 4'h1;
          if (bit_r == 4'h7) begin
            bit_r <= 4'h0;
            ack_r <= 1'b1;
            rdack_r <= 1'b0;
            case (st_r)
              ST_DEV: begin
                if (sh_in[7:3] == `BRC_MCODE_TOP && !hs_o) begin
                  st_r <= ST_MCODE; // not acknowledged
                  ack_r <= 1'b0;
                  hs_o <= 1'b1; // set right after the master code byte, before the repeated start
                end else if (sh_in[7:1] == my_addr) begin
                  st_r <= sh_in[0] ? ST_RD : ST_OFS;
                  rdack_r <= 1'b1;
                end else begin
                  st_r <= ST_IDLE;
                  ack_r <= 1'b0;
                end
              end
              ST_OFS: begin
                addr_o <= sh_in;
                st_r <= ST_WR;
                rdack_r <= 1'b1;
              end
              ST_WR: begin
                wdata_o <= sh_in;
                wr_o <= 1'b1;
                rdack_r <= 1'b1;
              end
              ST_RD: begin
                addr_o <= addr_o + 8'h01; // auto increment
              end
              default: st_r <= ST_IDLE;
            endcase
          end
        end
      end else if (scl_fall) begin
        sda_oe_n_o <= 1'b1;
        if (ack_r && rdack_r)
          sda_oe_n_o <= 1'b0; // drive ack low
        else if (st_r == ST_RD && !ack_r)
          sda_oe_n_o <= rdata_i[3'd7 - bit_r[2:0]]; // drive only zeros of read data
        else if (st_r == ST_RD && ack_r)
          sda_oe_n_o <= 1'b1;
      end
    end
  end
endmodule

// >>> hw/brc_top.v
// Purpose: digital control of a programmable step-down regulator
// Assumes: analog indications arrive asynchronously; bus clock from master
// Notes: target voltage reported as microvolt code; switching control as levels
// =====================================================================
// Summary of operation
// - Enable pin low forces shutdown with all switching off.
// - Serial access and register contents survive while enable pin is low.
// - Power-on reset restores every register default.
// - Discharge bit plus disable state turns on output pull-down.
// - Enable rise with software enable starts a ramped soft start.
// - Synchronous rectification off during soft start.
// - Sixteen current-limit cycles: tri-state, wait 1700 us, restart soft start.
// - Both software enable bits reset to one.
// - Output on only if selected software enable bit set.
// - Target is 0.600 V plus code times 6.25 mV.
// - Select pin picks low or high setting register.
// - Rising slew rate 64 mV/us halving per code step.
// - Downward change stops switching until output reaches target.
// - Input lockout holds regulator off.
// - Filtered over-voltage indication stops switching.
// - Thermal indication disables switching until cleared.
// - Status register reads 81 when enabled and regulating.
// - Data line pulled low only, msb first.
// - Slave address C0, or C2 with alternate option.
// - Master code not acknowledged; high speed set right after the master code byte.
// - High speed ends only at stop.
// - Control reset bit restores defaults and reads zero.
// - Mode bits with select pin choose forced fixed frequency.
`timescale 1ns/1ns
module brc_top (
  input wire CORE_CLK_I, // core clock
  input wire RST_I, // power-on reset, sync high
  input wire CE_I, // clock enable
  input wire EN_PIN_I, // hardware enable
  input wire VOLTAGE_SELECT_PIN_I, // select pin
  input wire ALT_ADDR_I, // alternate address option
  input wire INPUT_LOW_LOCKOUT_I, // supply too low
  input wire INPUT_HIGH_GUARD_I, // supply too high
  input wire THERMAL_I, // thermal shutdown
  input wire CUR_LIMIT_I, // cycle ended in current limit
  input wire CYCLE_END_I, // switching cycle end
  input wire VOUT_AT_TARGET_I, // output reached target
  input wire SCL_I, // bus clock
  input wire SDA_I, // bus data in
  output reg SDA_OE_N_O, // bus data pull, active low
  output reg SWITCH_EN_O, // switching allowed
  output reg SYNC_RECT_EN_O, // synchronous rectification
  output reg TRISTATE_O, // output stage tri-state
  output reg DISCHARGE_O, // output pull-down load
  output reg FORCED_FIXED_FREQUENCY_O, // forced fixed frequency
  output reg [20:0] TARGET_UV_O, // reference in microvolts
  output reg HIGH_SPEED_BUS_MODE_O // bus in high speed
);
`include "brc_defines.vh"
  localparam PS_OFF = 3'd0, PS_SOFT = 3'd1, PS_RUN = 3'd2, PS_DOWN = 3'd3, PS_HICCUP = 3'd4;
  localparam [31:0] HICCUP_CYC = `BRC_HICCUP_CYC;

  // full code range reaches 1.39375 V, so 21 bits of microvolts
  function [20:0] code_to_uv;
    input [6:0] code;
    begin
      code_to_uv = 21'd600000 + ({14'd0, code} * 21'd6250);
    end
  endfunction

  // =====================================================================
  // input synchronisers
  reg [11:0] s1_r, s2_r;
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      s1_r <= 12'h000;
      s2_r <= 12'h000;
    end else if (CE_I) begin
      s1_r <= {SCL_I, SDA_I, EN_PIN_I, VOLTAGE_SELECT_PIN_I, ALT_ADDR_I, INPUT_LOW_LOCKOUT_I,
               INPUT_HIGH_GUARD_I, THERMAL_I, CUR_LIMIT_I, CYCLE_END_I, VOUT_AT_TARGET_I, 1'b0};
      s2_r <= s1_r;
    end
  end
  wire scl_s = s2_r[11];
  wire sda_s = s2_r[10];
  wire en_s = s2_r[9];
  wire voltage_select_pin_s = s2_r[8];
  wire alt_s = s2_r[7];
  wire input_low_lockout_s = s2_r[6];
  wire ovp_s = s2_r[5];
  wire therm_s = s2_r[4];
  wire clim_s = s2_r[3];
  wire cyc_s = s2_r[2];
  wire at_tgt_s = s2_r[1];

  // =====================================================================
  // serial port
  wire [7:0] bus_addr, bus_wdata;
  wire bus_wr, bus_hs, bus_sda_oe_n;
  reg [7:0] rdata;
  brc_i2c_slave u_slave (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .alt_addr_i(alt_s),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .sda_oe_n_o(bus_sda_oe_n),
    .addr_o(bus_addr),
    .wdata_o(bus_wdata),
    .wr_o(bus_wr),
    .rdata_i(rdata),
    .hs_o(bus_hs)
  );

  // =====================================================================
  // registers; not cleared by the enable pin so content survives shutdown
  reg [7:0] setting_reg_low_r, setting_reg_high_r, control_r;
  reg [2:0] ps_r;
  wire soft_reset = bus_wr && bus_addr == `BRC_OFS_CONTROL && bus_wdata[`BRC_CTL_RESET];
  always @(posedge CORE_CLK_I) begin
    if (RST_I || (CE_I && soft_reset)) begin
      setting_reg_low_r <= `BRC_RST_SET; // both enables one
      setting_reg_high_r <= `BRC_RST_SET;
      control_r <= `BRC_RST_CONTROL;
    end else if (CE_I && bus_wr) begin
      case (bus_addr)
        `BRC_OFS_SET_LOW: setting_reg_low_r <= bus_wdata;
        `BRC_OFS_SET_HIGH: setting_reg_high_r <= bus_wdata;
        `BRC_OFS_CONTROL: control_r <= bus_wdata & 8'hf3; // reserved and reset read zero
        default: ;
      endcase
    end
  end

  wire sw_enable_low_sel = setting_reg_low_r[`BRC_SW_EN_BIT];
  wire sw_enable_high_sel = setting_reg_high_r[`BRC_SW_EN_BIT];
  wire sw_enable_bit = voltage_select_pin_s ? sw_enable_high_sel : sw_enable_low_sel;
  wire [6:0] output_code = voltage_select_pin_s ? setting_reg_high_r[6:0] : setting_reg_low_r[6:0];
  wire [2:0] slew_code = control_r[6:4];

  always @* begin
    case (bus_addr)
      `BRC_OFS_SET_LOW: rdata = setting_reg_low_r;
      `BRC_OFS_SET_HIGH: rdata = setting_reg_high_r;
      `BRC_OFS_CONTROL: rdata = control_r;
      `BRC_OFS_IDENT1: rdata = `BRC_IDENT1_VAL; // arbitrary value
      `BRC_OFS_IDENT2: rdata = `BRC_IDENT2_VAL; // arbitrary value
      `BRC_OFS_REG_STATE: rdata = (ps_r == PS_RUN) ? `BRC_STATE_OK : `BRC_STATE_OFF;
      default: rdata = 8'h00;
    endcase
  end

  // =====================================================================
  // fault gating
  reg [3:0] ovp_cnt_r;
  reg ovp_flt_r;
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ovp_cnt_r <= 4'h0;
      ovp_flt_r <= 1'b0;
    end else if (CE_I) begin
      // short spikes never reach the full count
      if (ovp_s != ovp_flt_r)
        ovp_cnt_r <= ovp_cnt_r + 4'h1;
      else
        ovp_cnt_r <= 4'h0;
      if (ovp_s != ovp_flt_r && ovp_cnt_r == `BRC_OVP_FILT)
        ovp_flt_r <= ovp_s;
    end
  end
  wire active = en_s && sw_enable_bit;
  wire fault = input_low_lockout_s || ovp_flt_r || therm_s;

  // =====================================================================
  // power sequencing
  reg en_d_r, cyc_d_r;
  reg [4:0] clim_cnt_r;
  reg [31:0] wait_r;
  reg [20:0] ref_r;
  reg [15:0] step_r;
  wire [20:0] target = code_to_uv(output_code);
  wire [15:0] step_cyc = 16'd25 << slew_code; // 6.25 mV step at 64 mV/us is ~24.4 cycles
  wire cyc_rise = cyc_s & ~cyc_d_r;
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ps_r <= PS_OFF;
      en_d_r <= 1'b0;
      cyc_d_r <= 1'b0;
      clim_cnt_r <= 5'd0;
      wait_r <= 32'd0;
      ref_r <= 21'd0;
      step_r <= 16'd0;
    end else if (CE_I) begin
      en_d_r <= en_s;
      cyc_d_r <= cyc_s;
      if (cyc_rise)
        clim_cnt_r <= clim_s ? clim_cnt_r + 5'd1 : 5'd0;
      step_r <= (step_r == 16'd0) ? 16'd0 : step_r - 16'd1;
      if (!active || fault) begin
        ps_r <= PS_OFF;
        ref_r <= 21'd0;
        clim_cnt_r <= 5'd0;
      end else begin
        case (ps_r)
          PS_OFF: if ((en_s && !en_d_r) || en_d_r) begin
            ps_r <= PS_SOFT;
            ref_r <= 21'd0;
          end
          PS_SOFT: begin
            if (step_r == 16'd0) begin
              step_r <= `BRC_SS_STEP_CYC;
              ref_r <= (ref_r + 21'd6250 >= target) ? target : ref_r + 21'd6250; // gradual
            end
            if (ref_r == target)
              ps_r <= PS_RUN;
          end
          PS_RUN: begin
            if (target < ref_r) begin
              ps_r <= PS_DOWN;
              ref_r <= target;
            end else if (target > ref_r && step_r == 16'd0) begin
              step_r <= step_cyc;
              ref_r <= (ref_r + 21'd6250 >= target) ? target : ref_r + 21'd6250;
            end
          end
          PS_DOWN: begin
            if (at_tgt_s)
              ps_r <= PS_RUN;
            ref_r <= target;
          end
          PS_HICCUP: begin
            if (wait_r == 32'd0) begin
              ps_r <= PS_SOFT;
              ref_r <= 21'd0;
            end else
              wait_r <= wait_r - 32'd1;
          end
          default: ps_r <= PS_OFF;
        endcase
        if (clim_cnt_r == `BRC_CLIM_COUNT && ps_r != PS_HICCUP) begin
          ps_r <= PS_HICCUP;
          wait_r <= HICCUP_CYC;
          clim_cnt_r <= 5'd0;
        end
      end
    end
  end

  // =====================================================================
  // registered outputs
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      SDA_OE_N_O <= 1'b1;
      SWITCH_EN_O <= 1'b0;
      SYNC_RECT_EN_O <= 1'b0;
      TRISTATE_O <= 1'b1;
      DISCHARGE_O <= 1'b0;
      FORCED_FIXED_FREQUENCY_O <= 1'b0;
      TARGET_UV_O <= 21'd0;
      HIGH_SPEED_BUS_MODE_O <= 1'b0;
    end else if (CE_I) begin
      SDA_OE_N_O <= bus_sda_oe_n;
      // gated by the live enable so these drop in the same cycle as the discharge load rises
      SWITCH_EN_O <= (ps_r == PS_SOFT || ps_r == PS_RUN) && active && !fault;
      SYNC_RECT_EN_O <= (ps_r == PS_RUN) && active && !fault;
      TRISTATE_O <= (ps_r == PS_OFF || ps_r == PS_HICCUP);
      DISCHARGE_O <= control_r[`BRC_CTL_DISCH] && !active;
      FORCED_FIXED_FREQUENCY_O <= voltage_select_pin_s ? control_r[1] : control_r[0];
      TARGET_UV_O <= ref_r;
      HIGH_SPEED_BUS_MODE_O <= bus_hs;
    end
  end
endmodule

// >>> tb/brc_bus_master.sv
// Purpose: bus master model driving the serial port of the regulator block
// Assumes: line pulled high; 125 ns bus clock period, clock idle high between frames
// Notes: sda_o is the resolved wire seen by both parties
`timescale 1ns/1ns
module brc_bus_master (
  input wire sda_oe_n_i, // slave pull, active low
  output reg scl_o, // bus clock
  output wire sda_o // resolved data line
);
  reg sda_m;
  assign sda_o = sda_m & sda_oe_n_i;
  initial begin
    scl_o = 1'b1;
    sda_m = 1'b1;
  end
  // ====================================================================
  // bit level
  task bit_x(input logic b, output logic r);
    begin
      sda_m = b;
      #31 scl_o = 1'b1;
      #63 r = sda_o;
      scl_o = 1'b0;
      #31;
    end
  endtask
  // also serves as repeated start when the clock is low
  task start_c;
    begin
      sda_m = 1'b1;
      #31 scl_o = 1'b1;
      #31 sda_m = 1'b0;
      #31 scl_o = 1'b0;
      #31;
    end
  endtask
  task stop_c;
    begin
      sda_m = 1'b0;
      #31 scl_o = 1'b1;
      #31 sda_m = 1'b1;
      #63;
    end
  endtask
  task xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
    integer i;
    logic t;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(d[i], t);
        q[i] = t;
      end
      bit_x(ai, ak);
    end
  endtask
  // ====================================================================
  // register access
  task wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] dat, output logic [2:0] ak);
    logic [7:0] q;
    begin
      start_c;
      xfer(dev, 1'b1, q, ak[2]);
      xfer(ofs, 1'b1, q, ak[1]);
      xfer(dat, 1'b1, q, ak[0]);
      stop_c;
    end
  endtask
  // offset write, repeated start, read address, one byte then nack
  task rd(input logic [7:0] ofs, output logic [7:0] q);
    logic [7:0] x;
    logic k;
    begin
      start_c;
      xfer(8'hc0, 1'b1, x, k);
      xfer(ofs, 1'b1, x, k);
      start_c;
      xfer(8'hc1, 1'b1, x, k);
      xfer(8'hff, 1'b1, q, k);
      stop_c;
    end
  endtask
endmodule

// >>> tb/brc_top_monitor.sv
// Purpose: concurrent checks on the regulator control ports
// Assumes: CE_I held high; inputs pass a two-flop synchroniser
// Notes: repetition counts leave room for synchroniser latency
`timescale 1ns/1ns
module brc_top_monitor (
  input wire CORE_CLK_I, // core clock
  input wire RST_I, // sync reset
  input wire EN_PIN_I, // hardware enable
  input wire INPUT_LOW_LOCKOUT_I, // supply too low
  input wire INPUT_HIGH_GUARD_I, // supply too high
  input wire THERMAL_I, // thermal shutdown
  input wire SCL_I, // bus clock
  input wire SDA_OE_N_O, // bus data pull
  input wire SWITCH_EN_O, // switching allowed
  input wire SYNC_RECT_EN_O, // rectification
  input wire TRISTATE_O, // output tri-state
  input wire DISCHARGE_O, // pull-down load
  input wire HIGH_SPEED_BUS_MODE_O // high speed
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  reg [5:0] ovp_cnt_r;
  // ====================================================================
  // helper: consecutive cycles of over-voltage indication
  always @(posedge CORE_CLK_I) begin
    if (RST_I || !INPUT_HIGH_GUARD_I)
      ovp_cnt_r <= 6'h00;
    else if (ovp_cnt_r != 6'h3f)
      ovp_cnt_r <= ovp_cnt_r + 6'h01;
  end
  a_pin_low_off: assert property (!EN_PIN_I [*4] |=> !SWITCH_EN_O)
    else $error("switching while enable pin low");
  a_thermal_off: assert property (THERMAL_I [*4] |=> !SWITCH_EN_O)
    else $error("switching while hot");
  a_lockout_off: assert property (INPUT_LOW_LOCKOUT_I [*4] |=> !SWITCH_EN_O)
    else $error("switching under lockout");
  a_guard_off: assert property (ovp_cnt_r >= 6'h18 |-> !SWITCH_EN_O)
    else $error("switching under over-voltage");
  a_rect_after_ramp: assert property ($rose(SYNC_RECT_EN_O) |-> !$past(TRISTATE_O))
    else $error("rectification without preceding ramp");
  a_disch_idle: assert property (DISCHARGE_O |-> !SYNC_RECT_EN_O)
    else $error("discharge while running");
  a_tri_quiet: assert property (TRISTATE_O |-> !SWITCH_EN_O)
    else $error("switching while tri-stated");
  a_sda_scl_low: assert property ($changed(SDA_OE_N_O) |-> !SCL_I)
    else $error("data pull changed with clock high");
  a_hs_stop: assert property ($fell(HIGH_SPEED_BUS_MODE_O) |-> SCL_I)
    else $error("high speed left outside stop");
  c_run: cover property ($rose(SYNC_RECT_EN_O));
  c_hiccup: cover property ($rose(TRISTATE_O));
  c_hs: cover property ($rose(HIGH_SPEED_BUS_MODE_O));
endmodule
bind brc_top brc_top_monitor u_mon (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .EN_PIN_I(EN_PIN_I),
  .INPUT_LOW_LOCKOUT_I(INPUT_LOW_LOCKOUT_I), .INPUT_HIGH_GUARD_I(INPUT_HIGH_GUARD_I),
  .THERMAL_I(THERMAL_I), .SCL_I(SCL_I), .SDA_OE_N_O(SDA_OE_N_O), .SWITCH_EN_O(SWITCH_EN_O),
  .SYNC_RECT_EN_O(SYNC_RECT_EN_O), .TRISTATE_O(TRISTATE_O), .DISCHARGE_O(DISCHARGE_O),
  .HIGH_SPEED_BUS_MODE_O(HIGH_SPEED_BUS_MODE_O));

// >>> tb/brc_top_tb.sv
// Purpose: self-checking bench for the regulator control block
// Assumes: bus master model on the serial port
// Notes: hiccup wait not covered, its count is too long to simulate
`timescale 1ns/1ns
module brc_top_tb;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg en = 1'b0, voltage_select_pin = 1'b0, alt = 1'b0, input_low_lockout = 1'b0, input_high_guard = 1'b0;
  reg therm = 1'b0, clim = 1'b0, cyc_end = 1'b0, vat = 1'b0;
  wire scl, sda, sda_oe_n, sw_en, rect, tri_st, disch, fff, hs;
  wire [20:0] tgt;
  integer num_errors = 0;
  integer tests_run = 0;
  always #2 core_clk = ~core_clk;
  brc_bus_master m (.sda_oe_n_i(sda_oe_n), .scl_o(scl), .sda_o(sda));
  brc_top dut (.CORE_CLK_I(core_clk), .RST_I(rst), .CE_I(1'b1), .EN_PIN_I(en), .VOLTAGE_SELECT_PIN_I(voltage_select_pin),
    .ALT_ADDR_I(alt), .INPUT_LOW_LOCKOUT_I(input_low_lockout), .INPUT_HIGH_GUARD_I(input_high_guard), .THERMAL_I(therm),
    .CUR_LIMIT_I(clim), .CYCLE_END_I(cyc_end), .VOUT_AT_TARGET_I(vat), .SCL_I(scl), .SDA_I(sda),
    .SDA_OE_N_O(sda_oe_n), .SWITCH_EN_O(sw_en), .SYNC_RECT_EN_O(rect), .TRISTATE_O(tri_st),
    .DISCHARGE_O(disch), .FORCED_FIXED_FREQUENCY_O(fff), .TARGET_UV_O(tgt), .HIGH_SPEED_BUS_MODE_O(hs));
  // ====================================================================
  // checking and closing
  task chk(input logic [20:0] g, input logic [20:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("Error t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("errors %0d of %0d comparisons", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(negedge core_clk);
    end
  endtask
  // ~41k cycles expected; limit at 100k
  initial begin
    #400000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  // ====================================================================
  // main sequence
  initial begin
    integer n;
    logic [7:0] q;
    logic [2:0] ak;
    logic k;
    cyc(16);
    rst = 1'b0;
    cyc(8);
    m.rd(8'h00, q); chk(q, 8'hc8);
    m.rd(8'h01, q); chk(q, 8'hc8);
    m.rd(8'h02, q); chk(q, 8'h82);
    m.rd(8'h05, q); chk(q, 8'h00);
    chk(sw_en, 1'b0);
    chk(tri_st, 1'b1);
    chk(disch, 1'b1);
    m.wr(8'hc0, 8'h00, 8'h81, ak); chk(ak, 3'b000);
    m.rd(8'h00, q); chk(q, 8'h81);
    m.wr(8'hc2, 8'h01, 8'hff, ak); chk(ak[2], 1'b1);
    alt = 1'b1;
    m.wr(8'hc2, 8'h01, 8'h80, ak); chk(ak, 3'b000);
    alt = 1'b0;
    m.start_c;
    m.xfer(8'h08, 1'b1, q, k); chk(k, 1'b1);
    m.start_c;
    m.xfer(8'hc0, 1'b1, q, k); chk(k, 1'b0);
    chk(hs, 1'b1);
    m.stop_c;
    chk(hs, 1'b0);
    @(negedge core_clk);
    en = 1'b1;
    cyc(10);
    chk(sw_en, 1'b1);
    chk(rect, 1'b0);
    chk(disch, 1'b0);
    for (n = 0; n < 40000 && rect !== 1'b1; n = n + 1) @(negedge core_clk);
    chk(rect, 1'b1);
    chk(tgt, 21'd606250);
    chk(fff, 1'b0);
    m.rd(8'h05, q); chk(q, 8'h81);
    @(negedge core_clk);
    voltage_select_pin = 1'b1;
    cyc(20);
    chk(sw_en, 1'b0);
    chk(tgt, 21'd600000);
    chk(fff, 1'b1);
    vat = 1'b1;
    cyc(20);
    chk(sw_en, 1'b1);
    therm = 1'b1;
    cyc(10);
    chk(sw_en, 1'b0);
    therm = 1'b0;
    cyc(10);
    chk(sw_en, 1'b1);
    input_high_guard = 1'b1;
    cyc(4);
    input_high_guard = 1'b0;
    cyc(10);
    chk(sw_en, 1'b1);
    input_high_guard = 1'b1;
    cyc(40);
    chk(sw_en, 1'b0);
    input_high_guard = 1'b0;
    input_low_lockout = 1'b1;
    cyc(10);
    chk(sw_en, 1'b0);
    input_low_lockout = 1'b0;
    m.wr(8'hc0, 8'h01, 8'h00, ak);
    cyc(10);
    chk(sw_en, 1'b0);
    chk(disch, 1'b1);
    m.wr(8'hc0, 8'h01, 8'h80, ak);
    cyc(10);
    for (n = 0; n < 32; n = n + 1) begin
      clim = (n != 15);
      cyc_end = 1'b1;
      cyc(4);
      cyc_end = 1'b0;
      cyc(4);
      if (n == 30) chk(tri_st, 1'b0);
    end
    chk(tri_st, 1'b1);
    chk(sw_en, 1'b0);
    m.wr(8'hc0, 8'h02, 8'h86, ak);
    m.rd(8'h02, q); chk(q, 8'h82);
    m.rd(8'h00, q); chk(q, 8'hc8);
    wrap_up;
  end
endmodule
